// *** oscsc_pkg.sv ***
// Constants, encodings and register map of the oscillator source control block.
// Assumes a single 25 MHz bus clock and configuration fields that are static after reset.
// Summary of operation
// (RULE1) Crystal modes count 1024 oscillations before release
// (RULE2) Timer runs after power-up delay, every wake
// (RULE3) Program counter held while timer counts
// (RULE4) Multiplier on by configuration or software bit
// (RULE5) Configuration enable makes software bit ignored
// (RULE6) Multiplier takes external or internal input
// (RULE7) Resistor-capacitor/internal modes: secondary pin GPIO/clock-out
// (RULE8) Internal mode releases primary input as GPIO
// (RULE9) Type field default; software selects internal block
// (RULE10) High clock made from medium via loop
// (RULE11) Low-frequency 31 kHz internal source provided
// (RULE12) Tuning value adjusts high and medium oscillators
// (RULE13) Frequency select field drives postscaler multiplexer
// (RULE14) High oscillator enabled under select and mode
// (RULE15) Medium oscillator enabled under select and mode
// (RULE16) High ready flag when oscillator usable
// (RULE17) High locked flag within two percent
// (RULE18) High stable flag within half percent
// (RULE19) Medium ready flag when oscillator usable
// (RULE20) Timer crystal oscillator selectable at run time
// (RULE21) Select field: 00 default, 01 timer, 1x internal
// (RULE22) Frequency select resets to 0111
// (RULE23) Logic-level clock mode bypasses the start-up timer
// (RULE24) Counter restarts on each event, full count releases
package oscsc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_TUNING  = 8'h08;

  // Control register fields
  localparam int CTRL_SCS_LSB   = 0;
  localparam int CTRL_INTERNAL_FREQUENCY_SELECT_LSB  = 3;
  localparam int CTRL_SPLL_BIT  = 7;

  // Status register fields
  localparam int STAT_HF_READY  = 0;
  localparam int STAT_HF_LOCKED = 1;
  localparam int STAT_HF_STABLE = 2;
  localparam int STAT_MF_READY  = 3;
  localparam int STAT_LF_ON     = 4;
  localparam int STAT_STARTED   = 5;

  // Reset values
  localparam logic [3:0] INTERNAL_FREQUENCY_SELECT_RESET = 4'h7;
  localparam logic [1:0] SCS_RESET  = 2'h0;
  localparam logic [4:0] TUNE_RESET = 5'h00;

  // Oscillator type field encodings
  localparam logic [2:0] OSC_LP     = 3'h0;
  localparam logic [2:0] OSC_XT     = 3'h1;
  localparam logic [2:0] OSC_HS     = 3'h2;
  localparam logic [2:0] OSC_RC     = 3'h3;
  localparam logic [2:0] OSC_INT    = 3'h4;

  // System clock select encodings
  localparam logic [1:0] SCS_DEFAULT = 2'h0;
  localparam logic [1:0] SCS_TIMER   = 2'h1;

  // Frequency select boundaries: 000x low, 0010..0111 medium, 1xxx high
  localparam logic [3:0] INTERNAL_FREQUENCY_SELECT_MF_MIN = 4'h2;

  // Start-up oscillation count and clock-out divider width
  localparam int STARTUP_OSC_COUNT = 1024;
  localparam int CLKOUT_DIV_BITS   = 2;

  // Source of the system clock
  typedef enum logic [1:0] {
    SRC_PRIMARY  = 2'b00,
    SRC_TIMER    = 2'b01,
    SRC_INTERNAL = 2'b10
  } oscsc_src_t;

  // Internal oscillator picked by the frequency select field
  typedef enum logic [1:0] {
    INT_LF = 2'b00,
    INT_MF = 2'b01,
    INT_HF = 2'b10
  } oscsc_int_t;

  // Start-up sequencer
  typedef enum logic [1:0] {
    ST_EVAL  = 2'b00,
    ST_POWER_UP_DELAY_TIMER  = 2'b01,
    ST_COUNT = 2'b10,
    ST_RUN   = 2'b11
  } oscsc_state_t;

endpackage

// *** oscsc_top.sv ***
// Oscillator source control: start-up timer, multiplier enable, pin functions,
// internal oscillator enables and status flags, AHB-Lite register slave.
// Assumes oscillator pin and analog status inputs are synchronous to hclk.
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/10ps

module oscsc_top
  import oscsc_pkg::*;
#(
  parameter int STARTUP_COUNT = STARTUP_OSC_COUNT,
  parameter int CNT_W         = 11
) (
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Configuration word fields
  input  wire logic [2:0]  oscillator_type_field,
  input  wire logic        config_multiplier_enable,
  input  wire logic        clock_output_select_n,
  input  wire logic        power_up_delay_timer_enabled,
  // Start-up events
  input  wire logic        power_up_delay_timer_expired,
  input  wire logic        wake_from_sleep,
  input  wire logic        primary_oscillator_input,
  output logic             cpu_hold,
  // Analog oscillator status
  input  wire logic        hf_osc_running,
  input  wire logic        hf_within_coarse,
  input  wire logic        hf_within_fine,
  input  wire logic        mf_osc_running,
  // Clock tree controls
  output oscsc_src_t       system_clock_source,
  output logic             multiplier_enable,
  output logic             multiplier_input_internal,
  output logic             high_freq_internal_clock_enable,
  output logic             internal_loop_multiplier_enable,
  output logic             medium_freq_internal_clock_enable,
  output logic             low_freq_internal_clock_enable,
  output logic [3:0]       postscaler_select,
  output logic [4:0]       oscillator_tune,
  // Oscillator pins
  output logic             primary_pin_gpio,
  output logic             secondary_pin_gpio,
  output logic             secondary_pin_out,
  output logic             secondary_pin_oe
);

  // Decode of the frequency select field into an oscillator
  function automatic oscsc_int_t internal_frequency_select_source(input logic [3:0] sel);
    if (sel[3]) begin
      internal_frequency_select_source = INT_HF;
    end else if (sel >= INTERNAL_FREQUENCY_SELECT_MF_MIN) begin
      internal_frequency_select_source = INT_MF;
    end else begin
      internal_frequency_select_source = INT_LF;
    end
  endfunction

  function automatic logic is_crystal(input logic [2:0] t);
    is_crystal = (t == OSC_LP) || (t == OSC_XT) || (t == OSC_HS);
  endfunction

  // Counter width must hold STARTUP_COUNT - 1
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STARTUP_COUNT - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // ---------------- Register slave ----------------
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  addr_q,    addr_d;
  logic        spll_q,    spll_d;
  logic [3:0]  internal_frequency_select_q,    internal_frequency_select_d;
  logic [1:0]  scs_q,     scs_d;
  logic [4:0]  tune_q,    tune_d;
  logic [31:0] rdata_q,   rdata_d;
  logic [31:0] status_word;
  logic [31:0] control_word;
  logic        addr_phase;
  logic        wr_take;
  logic        rd_take;

  // Status flags
  logic hf_ready_q,  hf_ready_d;
  logic hf_locked_q, hf_locked_d;
  logic hf_stable_q, hf_stable_d;
  logic mf_ready_q,  mf_ready_d;

  // Start-up sequencer
  oscsc_state_t     state_q, state_d;
  logic [CNT_W-1:0] cnt_q,   cnt_d;
  logic             osc_prev_q, osc_prev_d;
  logic [CLKOUT_DIV_BITS-1:0] div_q, div_d;

  // Derived controls
  logic       internal_mode;
  logic       int_allowed;
  oscsc_int_t int_pick;
  logic       rc_or_int;

  // Sequencer inputs and shared flag term
  logic       xtal_mode;
  logic       osc_rise;
  logic       wake_restart;
  logic       hf_live;

  // No wait states; a frozen block stalls the bus
  assign hreadyout  = clk_en;
  assign hresp      = 1'b0;
  assign hrdata     = rdata_q;
  assign addr_phase = hsel && htrans[1] && hready && clk_en;
  assign wr_take    = addr_phase && hwrite;
  assign rd_take    = addr_phase && !hwrite;

  always_comb begin
    control_word = 32'h0000_0000;
    control_word[CTRL_SCS_LSB +: 2]  = scs_q;
    control_word[CTRL_INTERNAL_FREQUENCY_SELECT_LSB +: 4] = internal_frequency_select_q;
    control_word[CTRL_SPLL_BIT]      = spll_q;
    status_word = 32'h0000_0000;
    status_word[STAT_HF_READY]  = hf_ready_q;
    status_word[STAT_HF_LOCKED] = hf_locked_q;
    status_word[STAT_HF_STABLE] = hf_stable_q;
    status_word[STAT_MF_READY]  = mf_ready_q;
    status_word[STAT_LF_ON]     = low_freq_internal_clock_enable;
    status_word[STAT_STARTED]   = (state_q == ST_RUN);
  end

  always_comb begin
    wr_pend_d = 1'b0;
    addr_d    = addr_q;
    spll_d    = spll_q;
    internal_frequency_select_d    = internal_frequency_select_q;
    scs_d     = scs_q;
    tune_d    = tune_q;
    rdata_d   = rdata_q;
    // Data phase of a write
    if (wr_pend_q) begin
      case (addr_q)
        ADDR_CONTROL: begin
          scs_d  = hwdata[CTRL_SCS_LSB +: 2];
          internal_frequency_select_d = hwdata[CTRL_INTERNAL_FREQUENCY_SELECT_LSB +: 4];
          spll_d = hwdata[CTRL_SPLL_BIT];
        end
        ADDR_TUNING: begin
          tune_d = hwdata[4:0];
        end
        default: begin
        end
      endcase
    end
    // Address phase; read data is loaded here for the following data phase
    if (addr_phase) begin
      addr_d    = haddr[7:0];
      wr_pend_d = wr_take;
      if (rd_take) begin
        case (haddr[7:0])
          ADDR_CONTROL: rdata_d = control_word;
          ADDR_STATUS:  rdata_d = status_word;
          ADDR_TUNING:  rdata_d = {27'h000_0000, tune_q};
          default:      rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
      spll_q    <= 1'b0;
      internal_frequency_select_q    <= INTERNAL_FREQUENCY_SELECT_RESET;  // [RULE22]
      scs_q     <= SCS_RESET;
      tune_q    <= TUNE_RESET;
      rdata_q   <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_q <= wr_pend_d;
      addr_q    <= addr_d;
      spll_q    <= spll_d;
      internal_frequency_select_q    <= internal_frequency_select_d;
      scs_q     <= scs_d;
      tune_q    <= tune_d;
      rdata_q   <= rdata_d;
    end
  end

  // ---------------- Clock source selection ----------------
  always_comb begin
    internal_mode = (oscillator_type_field == OSC_INT);
    int_allowed   = internal_mode || scs_q[1];
    int_pick      = internal_frequency_select_source(internal_frequency_select_q);
    rc_or_int     = internal_mode || (oscillator_type_field == OSC_RC);
    // Select field picks default, timer crystal or internal block
    if (scs_q[1]) begin
      system_clock_source = SRC_INTERNAL;  // [RULE9] [RULE21]
    end else if (scs_q == SCS_TIMER) begin
      system_clock_source = SRC_TIMER;     // [RULE20] [RULE21]
    end else if (internal_mode) begin
      system_clock_source = SRC_INTERNAL;  // [RULE9]
    end else begin
      system_clock_source = SRC_PRIMARY;   // [RULE21]
    end
    // Software bit only counts while the configuration bit is clear
    multiplier_enable         = config_multiplier_enable || spll_q;  // [RULE4] [RULE5]
    multiplier_input_internal = (system_clock_source == SRC_INTERNAL);  // [RULE6]
    high_freq_internal_clock_enable = int_allowed && (int_pick == INT_HF);  // [RULE14]
    // High clock is built from the medium oscillator by the loop
    internal_loop_multiplier_enable = high_freq_internal_clock_enable;  // [RULE10]
    medium_freq_internal_clock_enable = (int_allowed && (int_pick == INT_MF))  // [RULE15]
                                        || high_freq_internal_clock_enable;    // [RULE10]
    low_freq_internal_clock_enable = int_allowed && (int_pick == INT_LF);  // [RULE11]
    postscaler_select = internal_frequency_select_q;  // [RULE13]
    oscillator_tune   = tune_q;  // [RULE12]
  end

  // ---------------- Status flags ----------------
  // Flags follow enable and status one cycle late
  always_comb begin
    hf_live     = high_freq_internal_clock_enable && hf_osc_running;
    hf_ready_d  = hf_live;  // [RULE16]
    hf_locked_d = hf_live && hf_within_coarse;  // [RULE17]
    hf_stable_d = hf_live && hf_within_fine;  // [RULE18]
    mf_ready_d  = medium_freq_internal_clock_enable && mf_osc_running;  // [RULE19]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hf_ready_q  <= 1'b0;
      hf_locked_q <= 1'b0;
      hf_stable_q <= 1'b0;
      mf_ready_q  <= 1'b0;
    end else if (clk_en) begin
      hf_ready_q  <= hf_ready_d;
      hf_locked_q <= hf_locked_d;
      hf_stable_q <= hf_stable_d;
      mf_ready_q  <= mf_ready_d;
    end
  end

  // ---------------- Start-up timer ----------------
  // Edge detector idles low, as the stopped pin does
  always_comb begin
    xtal_mode    = is_crystal(oscillator_type_field);
    osc_rise     = primary_oscillator_input && !osc_prev_q;
    // Wake ignored until the power-on path reaches the count
    wake_restart = wake_from_sleep && (state_q != ST_EVAL) && (state_q != ST_POWER_UP_DELAY_TIMER);
  end

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    osc_prev_d = primary_oscillator_input;
    div_d      = div_q + 1'b1;
    case (state_q)
      // Entered on release of power-on reset
      ST_EVAL: begin
        cnt_d = CNT_ZERO;
        if (!xtal_mode) begin
          state_d = ST_RUN;  // [RULE23]
        end else if (power_up_delay_timer_enabled) begin
          state_d = ST_POWER_UP_DELAY_TIMER;  // [RULE2]
        end else begin
          state_d = ST_COUNT;  // [RULE2]
        end
      end
      ST_POWER_UP_DELAY_TIMER: begin
        cnt_d = CNT_ZERO;
        if (power_up_delay_timer_expired) begin
          state_d = ST_COUNT;  // [RULE2]
        end
      end
      ST_COUNT: begin
        // Rising edges on the primary input are oscillations
        if (osc_rise) begin
          if (cnt_q == CNT_LAST) begin
            state_d = ST_RUN;  // [RULE1] [RULE24]
          end else begin
            cnt_d = cnt_q + 1'b1;  // [RULE1]
          end
        end
      end
      ST_RUN: begin
        cnt_d = CNT_ZERO;
      end
      default: begin
        state_d = ST_EVAL;
        cnt_d   = CNT_ZERO;
      end
    endcase
    // Wake restarts the count from zero, overriding any count in progress
    if (wake_restart) begin
      cnt_d = CNT_ZERO;  // [RULE24]
      if (xtal_mode) begin
        state_d = ST_COUNT;  // [RULE2]
      end else begin
        state_d = ST_RUN;  // [RULE23]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= ST_EVAL;
      cnt_q      <= CNT_ZERO;
      osc_prev_q <= 1'b0;
      div_q      <= '0;
    end else if (clk_en) begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      osc_prev_q <= osc_prev_d;
      div_q      <= div_d;
    end
  end

  // Execution stalls until the sequencer reaches run
  assign cpu_hold = (state_q != ST_RUN);  // [RULE3]

  // ---------------- Oscillator pins ----------------
  always_comb begin
    primary_pin_gpio   = internal_mode;  // [RULE8]
    secondary_pin_gpio = 1'b0;
    secondary_pin_out  = 1'b0;
    secondary_pin_oe   = 1'b0;
    if (rc_or_int) begin
      if (!clock_output_select_n) begin
        // Quarter-rate copy of the bus clock
        secondary_pin_out = div_q[CLKOUT_DIV_BITS-1];  // [RULE7]
        secondary_pin_oe  = 1'b1;                      // [RULE7]
      end else begin
        secondary_pin_gpio = 1'b1;  // [RULE7]
      end
    end
  end

endmodule

// *** oscsc_top_assertions.sv ***
// Checker on the top ports of the oscillator source control block.
// Assumes clk_en high and STARTUP_COUNT equal to that of the top.
`timescale 1ns/10ps
module oscsc_top_assertions
  import oscsc_pkg::*;
#(
  parameter int STARTUP_COUNT = STARTUP_OSC_COUNT
) (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Configuration and events
  input wire logic [2:0] oscillator_type_field,
  input wire logic       config_multiplier_enable,
  input wire logic       clock_output_select_n,
  input wire logic       power_up_delay_timer_enabled,
  input wire logic       power_up_delay_timer_expired,
  input wire logic       wake_from_sleep,
  input wire logic       primary_oscillator_input,
  // Watched outputs
  input wire logic       cpu_hold,
  input wire logic [1:0] system_clock_source,
  input wire logic       multiplier_enable,
  input wire logic       high_freq_internal_clock_enable,
  input wire logic       medium_freq_internal_clock_enable,
  input wire logic [3:0] postscaler_select,
  input wire logic       primary_pin_gpio,
  input wire logic       secondary_pin_gpio,
  input wire logic       secondary_pin_out,
  input wire logic       secondary_pin_oe
);
  logic        prev_q;
  logic [11:0] cnt_q;
  logic        xtal;
  logic        rc_int;
  logic        is_int;

  assign xtal   = oscillator_type_field <= OSC_HS;
  assign is_int = (system_clock_source == SRC_INTERNAL) || (oscillator_type_field == OSC_INT);
  assign rc_int = oscillator_type_field inside {OSC_RC, OSC_INT};

  // Oscillation rises seen while held, cleared by wake or release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b0;
      cnt_q  <= 12'h000;
    end else begin
      prev_q <= primary_oscillator_input;
      if (wake_from_sleep || !cpu_hold) begin
        cnt_q <= 12'h000;
      end else if (primary_oscillator_input && !prev_q) begin
        cnt_q <= cnt_q + 12'h001;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_cfg_mult; config_multiplier_enable |-> multiplier_enable; endproperty
  a_cfg_mult: assert property (p_cfg_mult)
    else $error("multiplier off while configured on");
  property p_pri_gpio; primary_pin_gpio == (oscillator_type_field == OSC_INT); endproperty
  a_pri_gpio: assert property (p_pri_gpio)
    else $error("primary pin function wrong");
  property p_sec_fn;
    {secondary_pin_gpio, secondary_pin_oe} == (rc_int ? {clock_output_select_n, !clock_output_select_n} : 2'b00);
  endproperty
  a_sec_fn: assert property (p_sec_fn)
    else $error("secondary pin function wrong");
  property p_clkout; secondary_pin_oe && $rose(secondary_pin_out) |=> secondary_pin_out ##1 !secondary_pin_out; endproperty
  a_clkout: assert property (p_clkout)
    else $error("clock out not a quarter rate wave");
  property p_no_ost; !xtal && $past(hresetn) |-> !cpu_hold; endproperty
  a_no_ost: assert property (p_no_ost)
    else $error("hold in a mode without start-up count");
  property p_count; xtal && $fell(cpu_hold) |-> cnt_q == STARTUP_COUNT; endproperty
  a_count: assert property (p_count)
    else $error("release after wrong oscillation count");
  property p_wake; xtal && !cpu_hold && wake_from_sleep |=> cpu_hold; endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not restart start-up");
  property p_power_up_delay_timer; xtal && power_up_delay_timer_enabled && !power_up_delay_timer_expired |-> cpu_hold; endproperty
  a_power_up_delay_timer: assert property (p_power_up_delay_timer)
    else $error("released before power-up delay");
  property p_hf_en; high_freq_internal_clock_enable == (postscaler_select[3] && is_int); endproperty
  a_hf_en: assert property (p_hf_en)
    else $error("high oscillator enable wrong");
  property p_mf_en; medium_freq_internal_clock_enable == (postscaler_select >= INTERNAL_FREQUENCY_SELECT_MF_MIN && is_int); endproperty
  a_mf_en: assert property (p_mf_en)
    else $error("medium oscillator enable wrong");
  property p_dflt;
    $rose(hresetn) |-> postscaler_select == INTERNAL_FREQUENCY_SELECT_RESET &&
      system_clock_source == (oscillator_type_field == OSC_INT ? SRC_INTERNAL : SRC_PRIMARY);
  endproperty
  a_dflt: assert property (p_dflt)
    else $error("reset source or frequency wrong");

  c_release: cover property (xtal && $fell(cpu_hold));
  c_wake: cover property (xtal && wake_from_sleep && cpu_hold);
  c_clkout: cover property (secondary_pin_oe && $rose(secondary_pin_out));
endmodule

bind oscsc_top oscsc_top_assertions #(.STARTUP_COUNT(STARTUP_COUNT)) u_chk (.*);

// *** oscsc_xtal.sv ***
// Crystal or external clock model driving the primary oscillator input.
// Assumes the bench raises run only while the oscillator should swing.
`timescale 1ns/10ps
module oscsc_xtal #(
  parameter int HALF = 2
) (
  // Clock and control
  input wire logic hclk,
  input wire logic run,
  // Oscillator output
  output logic     osc
);
  int cnt = 0;

  initial osc = 1'b0;

  // Stands still low while stopped
  always @(posedge hclk) begin
    if (!run) begin
      osc <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      osc <= !osc;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** oscsc_top_tb.sv ***
// Self-checking bench of the oscillator source control block.
// Assumes the checker is bound and the crystal model feeds the primary input.
`timescale 1ns/10ps
module oscsc_top_tb;
  import oscsc_pkg::*;
  localparam int N = 8;
  logic        hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'h2, oscillator_type_field = OSC_INT;
  logic        config_multiplier_enable = 1'b0, clock_output_select_n = 1'b1;
  logic        power_up_delay_timer_enabled = 1'b0, power_up_delay_timer_expired = 1'b1;
  logic        wake_from_sleep = 1'b0, run = 1'b0, hf_osc_running = 1'b0, hf_within_coarse = 1'b0;
  logic        hf_within_fine = 1'b0, mf_osc_running = 1'b0, hready, hreadyout, hresp;
  logic        primary_oscillator_input, cpu_hold, multiplier_enable, multiplier_input_internal;
  logic        high_freq_internal_clock_enable, internal_loop_multiplier_enable;
  logic        medium_freq_internal_clock_enable, low_freq_internal_clock_enable;
  logic        primary_pin_gpio, secondary_pin_gpio, secondary_pin_out, secondary_pin_oe;
  logic [3:0]  postscaler_select;
  logic [4:0]  oscillator_tune;
  oscsc_src_t  system_clock_source;
  int          err_count = 0;
  int          checks_done = 0;

  always #20 hclk = ~hclk;
  assign hready = hreadyout;

  oscsc_top #(.STARTUP_COUNT(N)) u_dut (.*);
  oscsc_xtal u_xtal (.hclk(hclk), .run(run), .osc(primary_oscillator_input));

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single transfer, then one spare edge so outputs settle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
    @(posedge hclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rdat & m, e);
  endtask

  task automatic ctl(input logic [3:0] f, input logic [1:0] s);
    bus(1'b1, ADDR_CONTROL, {24'h0, 1'b0, f, 1'b0, s});
  endtask

  task automatic rst(input logic [2:0] t, input logic c, input logic n, input logic p);
    hresetn <= 1'b0;
    oscillator_type_field <= t;
    config_multiplier_enable <= c;
    clock_output_select_n <= n;
    power_up_delay_timer_enabled <= p;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask

  task automatic rises(input int n);
    repeat (n) @(posedge primary_oscillator_input);
    repeat (2) @(posedge hclk);
  endtask

  // Oscillator stops, then a wake pulse
  task automatic sleep_wake();
    run <= 1'b0;
    repeat (2) @(posedge hclk);
    wake_from_sleep <= 1'b1;
    @(posedge hclk);
    wake_from_sleep <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic t_regs();
    rdc(ADDR_CONTROL, 32'hFF, {24'h0, 1'b0, INTERNAL_FREQUENCY_SELECT_RESET, 1'b0, SCS_RESET});
    rdc(ADDR_TUNING, 32'h1F, 32'h0);
    bus(1'b1, ADDR_TUNING, 32'h0F);
    rdc(ADDR_TUNING, 32'h1F, 32'h0F);
    cmp(oscillator_tune, 5'h0F);
    bus(1'b1, 8'h0C, 32'hFF);
    rdc(8'h0C, 32'hFFFFFFFF, 32'h0);
  endtask

  task automatic t_src();
    rst(OSC_LP, 1'b0, 1'b1, 1'b0);
    cmp(system_clock_source, SRC_PRIMARY);
    for (int s = 0; s < 4; s++) begin
      ctl(INTERNAL_FREQUENCY_SELECT_RESET, 2'(s));
      cmp(system_clock_source, s == 0 ? SRC_PRIMARY : s == 1 ? SRC_TIMER : SRC_INTERNAL);
      cmp(multiplier_input_internal, s > 1);
    end
    bus(1'b1, ADDR_CONTROL, 32'hB8);
    cmp(multiplier_enable, 1'b1);
    ctl(INTERNAL_FREQUENCY_SELECT_RESET, 2'b00);
    cmp(multiplier_enable, 1'b0);
    rst(OSC_LP, 1'b1, 1'b1, 1'b0);
    ctl(INTERNAL_FREQUENCY_SELECT_RESET, 2'b00);
    cmp(multiplier_enable, 1'b1);
  endtask

  task automatic t_freq();
    logic [3:0] fs [5] = '{4'h0, 4'h2, 4'h7, 4'h8, 4'hF};
    foreach (fs[i]) begin
      ctl(fs[i], 2'b10);
      cmp(postscaler_select, fs[i]);
      cmp({high_freq_internal_clock_enable, internal_loop_multiplier_enable,
           medium_freq_internal_clock_enable, low_freq_internal_clock_enable},
          {fs[i][3], fs[i][3], fs[i] >= 4'h2, fs[i] < 4'h2});
    end
    ctl(4'hF, 2'b00);
    cmp({high_freq_internal_clock_enable, medium_freq_internal_clock_enable}, 2'b00);
    ctl(4'hF, 2'b10);
    hf_osc_running <= 1'b1;
    hf_within_coarse <= 1'b1;
    mf_osc_running <= 1'b1;
    @(posedge hclk);
    rdc(ADDR_STATUS, 32'hF, 32'hB);
    hf_within_fine <= 1'b1;
    @(posedge hclk);
    rdc(ADDR_STATUS, 32'hF, 32'hF);
    ctl(4'h7, 2'b10);
    bus(1'b1, ADDR_STATUS, 32'h0);
    rdc(ADDR_STATUS, 32'hF, 32'h8);
  endtask

  task automatic t_pins();
    for (int t = 0; t < 8; t++) begin
      for (int n = 0; n < 2; n++) begin
        rst(3'(t), 1'b0, n[0], 1'b0);
        repeat (4) @(posedge hclk);
        cmp(primary_pin_gpio, t == 4);
        cmp({secondary_pin_gpio, secondary_pin_oe}, (t == 3 || t == 4) ? {n[0], !n[0]} : 2'b00);
        cmp(cpu_hold, t < 3);
      end
    end
  endtask

  task automatic t_count();
    power_up_delay_timer_expired <= 1'b0;
    rst(OSC_XT, 1'b0, 1'b1, 1'b1);
    repeat (20) @(posedge hclk);
    cmp(cpu_hold, 1'b1);
    power_up_delay_timer_expired <= 1'b1;
    repeat (2) @(posedge hclk);
    run <= 1'b1;
    rises(N - 1);
    cmp(cpu_hold, 1'b1);
    rises(1);
    cmp(cpu_hold, 1'b0);
    sleep_wake();
    cmp(cpu_hold, 1'b1);
    run <= 1'b1;
    rises(N / 2);
    sleep_wake();
    run <= 1'b1;
    rises(N - 1);
    cmp(cpu_hold, 1'b1);
    rises(1);
    cmp(cpu_hold, 1'b0);
  endtask

  initial begin
    rst(OSC_INT, 1'b0, 1'b1, 1'b0);
    t_regs();
    t_src();
    t_freq();
    t_pins();
    t_count();
    final_report();
  end

  // Whole run is under a thousand cycles
  initial begin
    #200000;
    err_count++;
    final_report();
  end
endmodule
